/* core/adc_config_regs.sv */
// Activity detection and signal generator configuration registers.
// Assumes a synchronous 8-bit register port decoded upstream of page select.
//
// Functional notes
// R1 - Auto power field picks user, interrupt, or interrupt-up/user-down ADC power.
// R2 - Monitor channel field picks channel one to four for activity watch.
// R3 - Output pin interrupt driven only when enabled and not recording.
// R4 - Detect-during-record keeps detection running while recording, else suspended.
// R5 - Generator channel field picks channel one to four for ultrasonic output.
// R6 - Clock source field picks oscillator, bit clock, control clock, or custom.
// R7 - External rate field reports 24.576, 6.144, 12.288 or 18.432 MHz.
// R8 - Phase one enable turns on first-phase detection via jack comparator.
// R9 - Software writes reset value to reserved bits; they read zero.
// R10 - Jack comparator works only while headset detect is enabled.
// R11 - Clock selection changes take effect only while processing idles.
`timescale 1ns/1ps
`default_nettype none
module adc_config_regs
   import adc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Device state
   input wire logic recording,
   input wire logic activity_event,
   input wire logic headset_detect_enable,
   input wire logic processing_busy,
   input wire logic adc_power_is_on,
   // Detection and generation controls
   output logic detect_enable,
   output logic phase_one_active,
   output logic [3:0] monitor_channel_onehot,
   output logic [3:0] generator_channel_onehot,
   output logic [1:0] activity_clock_source,
   output logic [1:0] external_clock_rate,
   output logic clock_change_pending,
   // ADC power requests
   output logic adc_power_up_req,
   output logic adc_power_down_req,
   // Serial data output pin interrupt
   output logic serial_data_output_pin_int,
   output logic serial_data_output_pin_int_oe
);
   logic [7:0] det_cfg_d;
   logic [7:0] det_cfg_q;
   logic [7:0] gen_cfg_d;
   logic [7:0] gen_cfg_q;
   logic [7:0] clk_cfg_d;
   logic [7:0] clk_cfg_q;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic [1:0] auto_power_select;
   logic [1:0] monitor_channel_select;
   logic [1:0] generator_channel_select;
   logic output_pin_interrupt_enable;
   logic detect_during_record_enable;
   logic phase_one_enable;
   logic [3:0] clk_applied;
   logic clk_pending;
   logic [3:0] mon_hit;
   logic [3:0] gen_hit;
   logic det_en_d;
   logic det_en_q;
   logic ph1_d;
   logic ph1_q;
   logic [3:0] mon_oh_d;
   logic [3:0] mon_oh_q;
   logic [3:0] gen_oh_d;
   logic [3:0] gen_oh_q;
   logic up_d;
   logic up_q;
   logic down_d;
   logic down_q;
   logic int_d;
   logic int_q;
   logic int_oe_d;
   logic int_oe_q;
   logic pend_q;
   logic [3:0] clk_q;

   assign auto_power_select = det_cfg_q[ADC_AUTO_POWER_LSB +: 2];
   assign monitor_channel_select = det_cfg_q[ADC_MONITOR_CH_LSB +: 2];
   assign output_pin_interrupt_enable = det_cfg_q[ADC_PIN_INT_BIT];
   assign detect_during_record_enable = det_cfg_q[ADC_DET_REC_BIT];
   assign generator_channel_select = gen_cfg_q[ADC_GEN_CH_LSB +: 2];
   assign phase_one_enable = clk_cfg_q[ADC_PHASE1_BIT];

   // A field past the top bit would alias bits of a neighbouring field
   if (ADC_AUTO_POWER_LSB + 2 > $bits(reg_wdata)) begin : g_bad_power_field
      $error("adc_config_regs: power field outside register");
   end
   if (ADC_EXT_RATE_LSB + 4 > $bits(reg_wdata)) begin : g_bad_clock_field
      $error("adc_config_regs: clock fields outside register");
   end

   // Channel decode, one comparator pair per channel
   for (genvar ch = 0; ch < $bits(mon_hit); ch++) begin : g_chan_decode
      assign mon_hit[ch] = (monitor_channel_select == 2'(ch)); // R2
      assign gen_hit[ch] = (generator_channel_select == 2'(ch)); // R5
   end

   // Register writes and reads
   always_comb begin
      det_cfg_d = det_cfg_q;
      gen_cfg_d = gen_cfg_q;
      clk_cfg_d = clk_cfg_q;
      rdata_d = rdata_q;
      if (reg_wr) begin
         unique case (reg_addr)
            ADC_DETECT_CFG_ADDR: begin
               // Illegal power mode write is dropped, keeping the old mode
               if (reg_wdata[ADC_AUTO_POWER_LSB +: 2] != ADC_AUTO_POWER_ILLEGAL) begin
                  det_cfg_d = reg_wdata & ADC_DETECT_CFG_MASK; // R1 R2 R3 R4 R9
               end
            end
            ADC_GEN_CFG_ADDR: gen_cfg_d = reg_wdata & ADC_GEN_CFG_MASK; // R5 R9
            ADC_CLOCK_CFG_ADDR: clk_cfg_d = reg_wdata & ADC_CLOCK_CFG_MASK; // R6 R7 R8 R9
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            ADC_DETECT_CFG_ADDR: rdata_d = det_cfg_q;
            ADC_GEN_CFG_ADDR: rdata_d = gen_cfg_q;
            ADC_CLOCK_CFG_ADDR: rdata_d = clk_cfg_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         det_cfg_q <= ADC_DETECT_CFG_RESET;
         gen_cfg_q <= ADC_GEN_CFG_RESET;
         clk_cfg_q <= ADC_CLOCK_CFG_RESET;
         rdata_q <= 8'h00;
      end else begin
         det_cfg_q <= det_cfg_d;
         gen_cfg_q <= gen_cfg_d;
         clk_cfg_q <= clk_cfg_d;
         rdata_q <= rdata_d;
      end
   end

   // Clock settings cross over only between processing cycles
   adc_sync_sel #(.WIDTH(4)) u_clk_hold (
      .mclk(mclk),
      .rstn(rstn),
      .requested(clk_cfg_q[ADC_EXT_RATE_LSB +: 4]), // R6 R7
      .busy(processing_busy), // R11
      .applied(clk_applied),
      .pending(clk_pending)
   );

   // Detection, channel and power controls
   always_comb begin
      // Detection pauses while recording unless allowed
      det_en_d = !recording || detect_during_record_enable; // R4
      // Comparator is unusable without headset detection
      ph1_d = phase_one_enable && headset_detect_enable; // R8 R10
      mon_oh_d = mon_hit; // R2
      gen_oh_d = gen_hit; // R5
      up_d = 1'b0;
      down_d = 1'b0;
      unique case (adc_power_mode_t'(auto_power_select))
         ADC_PWR_USER: ;
         ADC_PWR_IRQ: begin
            up_d = activity_event && !adc_power_is_on; // R1
            down_d = !activity_event && adc_power_is_on && !recording; // R1
         end
         ADC_PWR_IRQ_UP: up_d = activity_event && !adc_power_is_on; // R1
         default: ;
      endcase
      // Pin free for interrupt only outside recording
      int_oe_d = output_pin_interrupt_enable && !recording; // R3
      int_d = int_oe_d && activity_event && det_en_d; // R3
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         det_en_q <= 1'b0;
         ph1_q <= 1'b0;
         mon_oh_q <= 4'h0;
         gen_oh_q <= 4'h0;
         up_q <= 1'b0;
         down_q <= 1'b0;
         int_q <= 1'b0;
         int_oe_q <= 1'b0;
         pend_q <= 1'b0;
         clk_q <= 4'h0;
      end else begin
         det_en_q <= det_en_d;
         ph1_q <= ph1_d;
         mon_oh_q <= mon_oh_d;
         gen_oh_q <= gen_oh_d;
         up_q <= up_d;
         down_q <= down_d;
         int_q <= int_d;
         int_oe_q <= int_oe_d;
         pend_q <= clk_pending;
         clk_q <= clk_applied;
      end
   end

   assign reg_rdata = rdata_q;
   assign detect_enable = det_en_q;
   assign phase_one_active = ph1_q;
   assign monitor_channel_onehot = mon_oh_q;
   assign generator_channel_onehot = gen_oh_q;
   assign activity_clock_source = clk_q[3:2];
   assign external_clock_rate = clk_q[1:0];
   assign clock_change_pending = pend_q;
   assign adc_power_up_req = up_q;
   assign adc_power_down_req = down_q;
   assign serial_data_output_pin_int = int_q;
   assign serial_data_output_pin_int_oe = int_oe_q;
endmodule
`default_nettype wire

/* core/adc_sync_sel.sv */
// Clock setting holder: applies a requested clock setting only while idle.
// Assumes busy is a level from the processing logic in the same domain.
`timescale 1ns/1ps
`default_nettype none
module adc_sync_sel
   import adc_pkg::*;
#(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Request and processing state
   input wire logic [WIDTH-1:0] requested,
   input wire logic busy,
   // Applied setting
   output logic [WIDTH-1:0] applied,
   output logic pending
);
   if (WIDTH < 1) begin : g_bad_width
      $error("adc_sync_sel: WIDTH must be positive");
   end

   logic [WIDTH-1:0] applied_d;
   logic [WIDTH-1:0] applied_q;

   always_comb begin
      applied_d = applied_q;
      if (!busy) begin
         applied_d = requested; // R11
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         applied_q <= '0;
      end else begin
         applied_q <= applied_d;
      end
   end

   assign applied = applied_q;
   assign pending = (applied_q != requested);
endmodule
`default_nettype wire

/* inc/adc_pkg.sv */
// Constants for the activity detection configuration register bank.
// Assumes an 8-bit register port with 8-bit addresses.
package adc_pkg;
   localparam logic [7:0] ADC_DETECT_CFG_ADDR = 8'h1E;
   localparam logic [7:0] ADC_GEN_CFG_ADDR = 8'h1F;
   localparam logic [7:0] ADC_CLOCK_CFG_ADDR = 8'h20;
   localparam logic [7:0] ADC_DETECT_CFG_RESET = 8'h20;
   localparam logic [7:0] ADC_GEN_CFG_RESET = 8'h80;
   localparam logic [7:0] ADC_CLOCK_CFG_RESET = 8'h00;
   // Writable bit masks; reserved bits read zero
   localparam logic [7:0] ADC_DETECT_CFG_MASK = 8'hFA;
   localparam logic [7:0] ADC_GEN_CFG_MASK = 8'hC0;
   localparam logic [7:0] ADC_CLOCK_CFG_MASK = 8'hF4;
   // Field positions
   localparam int ADC_AUTO_POWER_LSB = 6;
   localparam int ADC_MONITOR_CH_LSB = 4;
   localparam int ADC_PIN_INT_BIT = 3;
   localparam int ADC_DET_REC_BIT = 1;
   localparam int ADC_GEN_CH_LSB = 6;
   localparam int ADC_CLK_SRC_LSB = 6;
   localparam int ADC_EXT_RATE_LSB = 4;
   localparam int ADC_PHASE1_BIT = 2;
   localparam logic [1:0] ADC_AUTO_POWER_ILLEGAL = 2'h3;

   typedef enum logic [1:0] {
      ADC_PWR_USER, ADC_PWR_IRQ, ADC_PWR_IRQ_UP, ADC_PWR_BAD
   } adc_power_mode_t;
   typedef enum logic [1:0] {
      ADC_CLK_OSC, ADC_CLK_BIT, ADC_CLK_CTRL, ADC_CLK_CUSTOM
   } adc_clk_src_t;
endpackage

/* testbench/adc_config_regs_checker.sv */
// Port checker for the activity configuration registers.
// Bound to adc_config_regs; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module adc_config_regs_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Device state
   input wire logic recording,
   input wire logic headset_detect_enable,
   input wire logic processing_busy,
   // Controls
   input wire logic detect_enable,
   input wire logic phase_one_active,
   input wire logic [3:0] monitor_channel_onehot,
   input wire logic [3:0] generator_channel_onehot,
   input wire logic [1:0] activity_clock_source,
   input wire logic [1:0] external_clock_rate,
   input wire logic serial_data_output_pin_int,
   input wire logic serial_data_output_pin_int_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_unmapped_read_zero: assert property (reg_rd && reg_addr > 8'h20 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_reserved_read_zero: assert property (reg_rd && reg_addr == 8'h1F |=> reg_rdata[5:0] == 6'h00)
      else $error("reserved bits read nonzero");
   a_monitor_chan_map: assert property (reg_wr && reg_addr == 8'h1E && reg_wdata[7:6] != 2'h3
      |-> ##2 monitor_channel_onehot == 4'h1 << $past(reg_wdata[5:4], 2))
      else $error("monitor channel wrong");
   a_gen_chan_map: assert property (reg_wr && reg_addr == 8'h1F
      |-> ##2 generator_channel_onehot == 4'h1 << $past(reg_wdata[7:6], 2))
      else $error("generator channel wrong");
   a_phase_one_gate: assert property (phase_one_active |-> $past(headset_detect_enable))
      else $error("phase one without headset detect");
   a_detect_idle_on: assert property ($past(rstn) && !$past(recording) |-> detect_enable)
      else $error("detection off while not recording");
   a_pin_quiet_rec: assert property (recording && $past(recording) |-> !serial_data_output_pin_int_oe)
      else $error("pin driven during recording");
   a_pin_int_driven: assert property (serial_data_output_pin_int |-> serial_data_output_pin_int_oe)
      else $error("interrupt without drive");
   a_clock_hold_busy: assert property ($past(processing_busy, 2)
      |-> $stable(activity_clock_source) && $stable(external_clock_rate))
      else $error("clock setting changed while busy");
endmodule
bind adc_config_regs adc_config_regs_checker adc_config_regs_checker_inst (.mclk, .rstn, .reg_wr,
   .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .recording, .headset_detect_enable,
   .processing_busy, .detect_enable, .phase_one_active, .monitor_channel_onehot,
   .generator_channel_onehot, .activity_clock_source, .external_clock_rate,
   .serial_data_output_pin_int, .serial_data_output_pin_int_oe);
`default_nettype wire

/* testbench/adc_config_regs_test.sv */
// Self-checking bench for the activity configuration registers.
// Drives every port itself; no partner model.
`timescale 1ns/1ps
`default_nettype none
module adc_config_regs_test import adc_pkg::*;;
   logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, recording = 1'b0;
   logic activity_event = 1'b0, headset_detect_enable = 1'b0, processing_busy = 1'b0;
   logic adc_power_is_on = 1'b0, detect_enable, phase_one_active, clock_change_pending;
   logic adc_power_up_req, adc_power_down_req, pin_int, pin_oe;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [3:0] mon_oh, gen_oh;
   logic [1:0] clk_src, ext_rate;
   int num_errors = 0, cmp_count = 0;
   always #2 mclk = ~mclk;
   adc_config_regs adc_config_regs_inst (.mclk, .rstn, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .recording, .activity_event, .headset_detect_enable,
      .processing_busy, .adc_power_is_on, .detect_enable, .phase_one_active,
      .monitor_channel_onehot(mon_oh), .generator_channel_onehot(gen_oh),
      .activity_clock_source(clk_src), .external_clock_rate(ext_rate), .clock_change_pending,
      .adc_power_up_req, .adc_power_down_req, .serial_data_output_pin_int(pin_int),
      .serial_data_output_pin_int_oe(pin_oe));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      chk(reg_rdata, exp);
   endtask
   // Settled look, off the clock edge
   task automatic see(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic t_reset;
      wr(8'h21, 8'hFF);
      rd(8'h1E, 8'h20);
      rd(8'h1F, 8'h80);
      rd(8'h20, 8'h00);
      rd(8'h21, 8'h00);
      chk(mon_oh, 8'h04);
      chk(gen_oh, 8'h04);
      $display("t_reset done");
   endtask
   task automatic t_chan;
      for (int i = 0; i < 4; i++) begin
         wr(8'h1E, {2'h0, i[1:0], 4'h0});
         wr(8'h1F, {i[1:0], 6'h00});
         see(2);
         chk(mon_oh, 8'h01 << i);
         chk(gen_oh, 8'h01 << i);
         rd(8'h1F, {i[1:0], 6'h00});
      end
      $display("t_chan done");
   endtask
   task automatic t_power;
      wr(8'h1E, 8'hC0);
      rd(8'h1E, 8'h30);
      wr(8'h1E, 8'h40);
      adc_power_is_on <= 1'b1;
      see(3);
      chk(adc_power_down_req, 8'h01);
      wr(8'h1E, 8'h80);
      see(3);
      chk(adc_power_down_req, 8'h00);
      wr(8'h1E, 8'h00);
      activity_event <= 1'b1;
      adc_power_is_on <= 1'b0;
      see(3);
      chk(adc_power_up_req, 8'h00);
      wr(8'h1E, 8'h80);
      see(3);
      chk(adc_power_up_req, 8'h01);
      chk(adc_power_down_req, 8'h00);
      $display("t_power done");
   endtask
   task automatic t_record;
      wr(8'h1E, 8'h08);
      recording <= 1'b1;
      see(3);
      chk(detect_enable, 8'h00);
      chk(pin_oe, 8'h00);
      @(posedge mclk);
      recording <= 1'b0;
      see(3);
      chk(pin_oe, 8'h01);
      chk(pin_int, 8'h01);
      wr(8'h1E, 8'h02);
      recording <= 1'b1;
      see(3);
      chk(detect_enable, 8'h01);
      chk(pin_oe, 8'h00);
      $display("t_record done");
   endtask
   task automatic t_clock;
      @(posedge mclk);
      processing_busy <= 1'b1;
      wr(8'h20, 8'hFF);
      see(6);
      chk(clk_src, 8'h00);
      chk(clock_change_pending, 8'h01);
      rd(8'h20, 8'hF4);
      for (int i = 0; i < 4; i++) begin
         wr(8'h20, {i[1:0], i[1:0], 4'h4});
         processing_busy <= 1'b0;
         headset_detect_enable <= i[0];
         see(3);
         chk(clk_src, i[1:0]);
         chk(ext_rate, i[1:0]);
         chk(phase_one_active, i[0]);
         chk(clock_change_pending, 8'h00);
      end
      $display("t_clock done");
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      t_reset;
      t_chan;
      t_power;
      t_record;
      t_clock;
      wrap_up;
   end
   // Hang guard
   initial begin
      #100000;
      num_errors++;
      wrap_up;
   end
endmodule
`default_nettype wire
